// [engine_ctl.v]
// Engine sequencing and protection with an AHB-Lite register slave.
// Assumes sensor inputs already synchronous to hclk; speed in rpm, charge in 0.1 V, temp in deg C.
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`include "engine_ctl_regs.vh"
module engine_ctl (
    input wire hclk, // Bus clock, 10 MHz
    input wire hresetn, // Async reset, active low
    input wire hsel, // Slave select
    input wire [11:0] haddr, // Byte address
    input wire [1:0] htrans, // Transfer type
    input wire hwrite, // Write strobe
    input wire [2:0] hsize, // Transfer size
    input wire [31:0] hwdata, // Write data
    input wire hready, // Bus ready
    output reg [31:0] hrdata, // Read data
    output reg hreadyout, // Slave ready
    output reg hresp, // Always OKAY
    input wire mains_fail, // Request to run the genset
    input wire [1:0] freq_sel, // 0 primary, 1 secondary, 2 tertiary
    input wire [15:0] engine_speed, // Measured rpm
    input wire speed_signal_ok, // Speed signal present
    input wire [9:0] charge_voltage, // Charge voltage in 0.1 V
    input wire [7:0] coolant_temp, // Coolant deg C
    input wire engine_running, // Engine fired
    output reg fuel_out, // Fuel solenoid
    output reg preheat_out, // Preheat relay
    output reg crank_out, // Crank relay
    output reg choke_out, // Choke relay
    output reg stop_out, // Stop solenoid
    output reg load_on_gen, // Genset may take load
    output reg shutdown_out, // Shutdown alarm active
    output reg loaddump_out, // Load dump alarm active
    output reg warning_out // Any warning active
);

localparam S_IDLE = 8'h01;
localparam S_DELAY = 8'h02;
localparam S_PREHEAT = 8'h04;
localparam S_CRANK = 8'h08;
localparam S_WAIT = 8'h10;
localparam S_HEAT = 8'h20;
localparam S_RUN = 8'h40;
localparam S_STOP = 8'h80;

reg [15:0] nom1_r, nom2_r, nom3_r;
reg [31:0] spdpct_r, spdcfg_r, chg_r, startt_r, runt_r;
reg ctrl_r; // Auto-run enable
reg [10:0] alarm_r;
reg [7:0] state_r;
reg [23:0] div_r;
reg tick_r;
reg [15:0] seq_r; // Sequence timer in seconds
reg [7:0] choke_r;
reg [2:0] tries_r;
reg cooling_r;
reg [3:0] spd_lo_r, spd_hi_r;
reg [7:0] sig_r;
reg [6:0] chg_t_r;
reg wr_pend_r;
reg [11:0] addr_r;

// Percent of nominal, result in rpm
function [17:0] pct_of;
    input [15:0] nom;
    input [7:0] pct;
    reg [23:0] prod;
    begin
        // Product kept at 24 bits so a 50000 rpm nominal cannot wrap
        prod = nom * pct;
        prod = prod / 24'd100;
        pct_of = prod[17:0];
    end
endfunction

wire [15:0] nom = (freq_sel == 2'd1) ? nom2_r : (freq_sel == 2'd2) ? nom3_r : nom1_r;

// Speed limits in rpm, all relative to the selected nominal
wire [17:0] lo_warn = {2'b00, nom} - pct_of(nom, spdpct_r[7:0]);
wire [17:0] hi_warn = {2'b00, nom} + pct_of(nom, spdpct_r[15:8]);
wire [17:0] lo_shut = {2'b00, nom} - pct_of(nom, spdpct_r[23:16]);
wire [17:0] hi_shut = {2'b00, nom} + pct_of(nom, spdpct_r[31:24]);
wire [17:0] over_lim = hi_shut + pct_of(nom, spdcfg_r[7:0]);
wire [17:0] spd = {2'b00, engine_speed};

// Fault conditions; no tick needed here, so a zero fail time trips at once
wire on_load = (state_r == S_RUN) && !cooling_r;
wire spd_low = on_load && (spd < lo_warn);
wire spd_high = on_load && (spd > hi_warn);
wire lo_fail = spd_low && (spd_lo_r >= spdcfg_r[11:8]);
wire hi_fail = spd_high && (spd_hi_r >= spdcfg_r[11:8]);
wire chg_low = (state_r == S_RUN || state_r == S_HEAT) && (charge_voltage < chg_r[9:0]);
wire chg_fail = chg_low && (chg_t_r >= chg_r[26:20]);
wire sig_lost = spdcfg_r[12] && !speed_signal_ok && (state_r == S_RUN || state_r == S_HEAT);
wire sig_fail = sig_lost && (sig_r >= spdcfg_r[22:15]);
wire shut = alarm_r[`AL_LOW_S] | alarm_r[`AL_HIGH_S] | alarm_r[`AL_SIG_S] | alarm_r[`AL_CHG_S] | alarm_r[`AL_STARTF];
wire dump = alarm_r[`AL_SIG_D];
wire [15:0] heat_t = {8'h00, runt_r[7:0]};
// Start delay is set in minutes; 720 min fits the 16-bit seconds timer
wire [15:0] start_dly = {6'h00, startt_r[9:0]} * 16'd60;

// hreadyout never drops, so every transfer completes without wait states

// Bus
wire acc = hsel && htrans[1] && hready;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        addr_r <= 12'h000;
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        wr_pend_r <= acc && hwrite;
        if (acc) begin
            addr_r <= haddr;
        end
        if (acc && !hwrite) begin
            case (haddr)
                `A_NOM1: hrdata <= {16'h0000, nom1_r};
                `A_NOM2: hrdata <= {16'h0000, nom2_r};
                `A_NOM3: hrdata <= {16'h0000, nom3_r};
                `A_SPDPCT: hrdata <= spdpct_r;
                `A_SPDCFG: hrdata <= spdcfg_r;
                `A_CHG: hrdata <= chg_r;
                `A_STARTT: hrdata <= startt_r;
                `A_RUNT: hrdata <= runt_r;
                `A_CTRL: hrdata <= {31'h00000000, ctrl_r};
                `A_STATUS: hrdata <= {21'h000000, tries_r, state_r};
                `A_ALARM: hrdata <= {21'h000000, alarm_r};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        nom1_r <= `RV_NOM1;
        nom2_r <= `RV_NOM2;
        nom3_r <= `RV_NOM3;
        spdpct_r <= `RV_SPDPCT;
        spdcfg_r <= `RV_SPDCFG;
        chg_r <= `RV_CHG;
        startt_r <= `RV_STARTT;
        runt_r <= `RV_RUNT;
        ctrl_r <= 1'b0;
    end else if (wr_pend_r) begin
        case (addr_r)
            `A_NOM1: nom1_r <= (hwdata[15:0] > 16'hc350) ? 16'hc350 : hwdata[15:0];
            `A_NOM2: nom2_r <= (hwdata[15:0] > 16'hc350) ? 16'hc350 : hwdata[15:0];
            `A_NOM3: nom3_r <= (hwdata[15:0] > 16'hc350) ? 16'hc350 : hwdata[15:0];
            `A_SPDPCT: spdpct_r <= hwdata;
            `A_SPDCFG: spdcfg_r <= hwdata;
            `A_CHG: chg_r <= hwdata;
            `A_STARTT: startt_r <= hwdata;
            `A_RUNT: runt_r <= hwdata;
            `A_CTRL: ctrl_r <= hwdata[0];
            default: ;
        endcase
    end
end

// One-second timebase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        div_r <= 24'h000000;
        tick_r <= 1'b0;
    end else if (div_r == (`TICK_CYC - 1)) begin
        div_r <= 24'h000000;
        tick_r <= 1'b1;
    end else begin
        div_r <= div_r + 24'h000001;
        tick_r <= 1'b0;
    end
end

// Fault persistence timers
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        spd_lo_r <= 4'h0;
        spd_hi_r <= 4'h0;
        sig_r <= 8'h00;
        chg_t_r <= 7'h00;
    end else begin
        if (!spd_low) spd_lo_r <= 4'h0;
        else if (tick_r && spd_lo_r != 4'hf) spd_lo_r <= spd_lo_r + 4'h1;
        if (!spd_high) spd_hi_r <= 4'h0;
        else if (tick_r && spd_hi_r != 4'hf) spd_hi_r <= spd_hi_r + 4'h1;
        if (!sig_lost) sig_r <= 8'h00;
        else if (tick_r && sig_r != 8'hff) sig_r <= sig_r + 8'h01;
        if (!chg_low) chg_t_r <= 7'h00;
        else if (tick_r && chg_t_r != 7'h7f) chg_t_r <= chg_t_r + 7'h01;
    end
end

// Alarms stay set until the run request is removed after the engine has stopped
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        alarm_r <= 11'h000;
    end else begin
        if (state_r == S_IDLE && !mains_fail) alarm_r <= 11'h000;
        if (lo_fail) alarm_r[`AL_LOW_W] <= 1'b1;
        if (hi_fail) alarm_r[`AL_HIGH_W] <= 1'b1;
        if (lo_fail && spd < lo_shut) alarm_r[`AL_LOW_S] <= 1'b1;
        if (hi_fail && spd > hi_shut) alarm_r[`AL_HIGH_S] <= 1'b1;
        if (on_load && spd > over_lim) alarm_r[`AL_HIGH_S] <= 1'b1;

        // Lost pickup action is chosen by software
        if (sig_fail) begin
            case (spdcfg_r[14:13])
                2'd0: alarm_r[`AL_SIG_S] <= 1'b1;
                2'd1: alarm_r[`AL_SIG_D] <= 1'b1;
                default: alarm_r[`AL_SIG_W] <= 1'b1;
            endcase
        end

        // Charge shutdown also raises the warning, as both limits are passed
        if (chg_fail) alarm_r[`AL_CHG_W] <= 1'b1;
        if (chg_fail && charge_voltage < chg_r[19:10]) alarm_r[`AL_CHG_S] <= 1'b1;
        if (state_r == S_STOP && tick_r && seq_r + 16'h0001 >= {10'h000, runt_r[31:26]} && engine_running)
            alarm_r[`AL_STOPF] <= 1'b1;
        if (state_r == S_WAIT && tries_r >= startt_r[29:27]) alarm_r[`AL_STARTF] <= 1'b1;
    end
end

// Sequencer
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_r <= S_IDLE;
        seq_r <= 16'h0000;
        choke_r <= 8'h00;
        tries_r <= 3'h0;
        cooling_r <= 1'b0;
    end else begin
        if (tick_r) seq_r <= seq_r + 16'h0001;
        if (tick_r && choke_r != 8'hff) choke_r <= choke_r + 8'h01;
        case (state_r)
            S_IDLE: begin
                seq_r <= 16'h0000;
                tries_r <= 3'h0;
                cooling_r <= 1'b0;
                if (ctrl_r && mains_fail && !shut) state_r <= S_DELAY;
            end

            // Mains may return during the delay; then nothing starts
            S_DELAY: begin
                if (!mains_fail || shut) state_r <= S_IDLE;
                else if (seq_r >= start_dly) begin
                    state_r <= S_PREHEAT;
                    seq_r <= 16'h0000;
                end
            end

            // Fuel is already on here; the first attempt is counted on leaving
            S_PREHEAT: begin
                if (shut) state_r <= S_STOP;
                else if (seq_r >= {11'h000, startt_r[14:10]}) begin
                    state_r <= S_CRANK;
                    seq_r <= 16'h0000;
                    choke_r <= 8'h00;
                    tries_r <= tries_r + 3'h1;
                end
            end

            // Firing wins over the crank limit in the same cycle
            S_CRANK: begin
                if (shut) begin
                    state_r <= S_STOP;
                    seq_r <= 16'h0000;
                end else if (engine_running) begin
                    state_r <= S_HEAT;
                    seq_r <= 16'h0000;
                end else if (seq_r >= {12'h000, startt_r[18:15]}) begin
                    state_r <= S_WAIT;
                    seq_r <= 16'h0000;
                end
            end

            // Out of attempts ends as a start failure shutdown
            S_WAIT: begin
                if (shut || tries_r >= startt_r[29:27]) begin
                    state_r <= S_STOP;
                    seq_r <= 16'h0000;
                end else if (seq_r >= {8'h00, startt_r[26:19]}) begin
                    state_r <= S_CRANK;
                    seq_r <= 16'h0000;
                    choke_r <= 8'h00;
                    tries_r <= tries_r + 3'h1;
                end
            end

            // Load is held off until heating ends
            S_HEAT: begin
                if (shut || dump || !mains_fail) begin
                    state_r <= S_STOP;
                    seq_r <= 16'h0000;
                end else if (seq_r >= heat_t && (!runt_r[15] || coolant_temp >= {1'b0, runt_r[14:8]})) begin
                    state_r <= S_RUN;
                    seq_r <= 16'h0000;
                end
            end

            // Mains return or a load dump starts the unloaded cooldown
            S_RUN: begin
                if (shut) begin
                    state_r <= S_STOP;
                    seq_r <= 16'h0000;
                end else if (!cooling_r && (!mains_fail || dump)) begin
                    cooling_r <= 1'b1;
                    seq_r <= 16'h0000;
                end else if (cooling_r && mains_fail && !dump) begin
                    cooling_r <= 1'b0;
                end else if (cooling_r && seq_r >= {6'h00, runt_r[25:16]}) begin
                    state_r <= S_STOP;
                    seq_r <= 16'h0000;
                end
            end

            // Leaves early once the engine is seen stopped after a tick
            S_STOP: begin
                cooling_r <= 1'b0;
                if (seq_r >= {10'h000, runt_r[31:26]} || (!engine_running && seq_r != 16'h0000))
                    state_r <= S_IDLE;
            end

            // Unreachable codes recover to idle
            default: state_r <= S_IDLE;
        endcase
    end
end

// Registered outputs
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        fuel_out <= 1'b0;
        preheat_out <= 1'b0;
        crank_out <= 1'b0;
        choke_out <= 1'b0;
        stop_out <= 1'b0;
        load_on_gen <= 1'b0;
        shutdown_out <= 1'b0;
        loaddump_out <= 1'b0;
        warning_out <= 1'b0;
    end else begin
        // Fuel stays on from preheat until the stop state
        fuel_out <= (state_r & (S_PREHEAT | S_CRANK | S_WAIT | S_HEAT | S_RUN)) != 8'h00;
        preheat_out <= state_r == S_PREHEAT;
        crank_out <= state_r == S_CRANK && !engine_running;
        // Fixed choke time, cut early once the engine fires
        choke_out <= state_r == S_CRANK && !engine_running && choke_r < `CHOKE_S;
        stop_out <= state_r == S_STOP;
        load_on_gen <= on_load && !shut && !dump;
        shutdown_out <= shut;
        loaddump_out <= dump;
        // Warning group: speed, lost signal, charge and stop failure
        warning_out <= (alarm_r & 11'h2c3) != 11'h000;
    end
end

endmodule // engine_ctl

// [engine_ctl_regs.vh]
// Constants for the engine start/stop and protection block: register offsets, field positions,
// reset values and timebase counts.
// Assumes a 10 MHz hclk and an AHB-Lite master that issues single 32-bit word transfers.
// Summary of operation
// - Primary nominal speed defaults to 1500 rpm, maximum 50000; limits derive from it.
// - Secondary or tertiary frequency selects the alternate nominal speed, default 1800 rpm.
// - On load, speed below nominal minus warning percent raises a low-speed warning.
// - On load, speed above nominal plus warning percent raises a high-speed warning.
// - On load, speed past 15 percent shutdown limits raises shutdown alarm and stops.
// - Speed faults are declared only after the fail time, default 3 s, maximum 10.
// - Speed beyond high shutdown limit plus overshoot trips shutdown immediately.
// - Signal check bit 0 disables lost-speed-signal detection; 1 enables it.
// - Lost signal action: 0 shutdown, 1 load dump, 2 warning only.
// - Lost signal fault needs absence for the loss delay, 0 to 240 s.
// - Charge voltage below warning limit, default 6.0 V, raises a warning.
// - Charge voltage below shutdown limit, default 4.0 V, shuts down and stops.
// - Charge faults need the condition for the charge fail time, default 1 s.
// - After mains failure wait start delay, default 1 min, then energise fuel.
// - After fuel on, drive preheat for the preheat time, at most 30 s.
// - Crank at most crank time, default 6 s, ending early once engine fires.
// - Wait inter-start period, default 10 s; at most start count attempts, default 3.
// - No load transfer before heating ends: by time, or temperature and time.
// - After load returns to mains, run unloaded for cooldown time, default 120 s.
// - Stop output up to stop solenoid time; warn on stop failure if still turning.
// - Choke starts with crank; released after choke delay or when engine runs.
`ifndef ENGINE_CTL_REGS_VH
`define ENGINE_CTL_REGS_VH

`define CLK_HZ 10000000
`define TICK_S 1
`define TICK_CYC (`CLK_HZ * `TICK_S)

// Byte addresses
`define A_NOM1 12'h000
`define A_NOM2 12'h004
`define A_NOM3 12'h008
`define A_SPDPCT 12'h00c
`define A_SPDCFG 12'h010
`define A_CHG 12'h014
`define A_STARTT 12'h018
`define A_RUNT 12'h01c
`define A_CTRL 12'h020
`define A_STATUS 12'h024
`define A_ALARM 12'h028

// Reset values
`define RV_NOM1 16'h05dc
`define RV_NOM2 16'h0708
`define RV_NOM3 16'h0708
// Percent fields: low warn, high warn, low shut, high shut
`define RV_SPDPCT 32'h0f0f0a0a
// Overshoot pct [7:0], fail time [11:8], signal check [12], action [14:13], loss delay [22:15]
`define RV_SPDCFG 32'h0000030a
// Warn limit 0.1 V [9:0], shut limit [19:10], fail time [26:20]
`define RV_CHG 32'h0010a03c
// Start delay min [9:0], preheat [14:10], crank [18:15], wait [26:19], starts [29:27]
`define RV_STARTT 32'h18530001
// Heat time [7:0], heat temp [14:8], method [15], cooldown [25:16], stop time [31:26]
`define RV_RUNT 32'h28780004
// Choke hold time in seconds; there is no register field for it
`define CHOKE_S 8'h05

// Alarm bit positions
`define AL_LOW_W 0
`define AL_HIGH_W 1
`define AL_LOW_S 2
`define AL_HIGH_S 3
`define AL_SIG_S 4
`define AL_SIG_D 5
`define AL_SIG_W 6
`define AL_CHG_W 7
`define AL_CHG_S 8
`define AL_STOPF 9
`define AL_STARTF 10

`endif

// [engine_model.sv]
// Engine and sensor model for the far side of engine_ctl.
// Assumes the bench sets running speed, pickup presence and charge level.
`timescale 1ns/10ps
module engine_model (
    input wire hclk, // Bus clock
    input wire fuel_out, // Fuel solenoid
    input wire crank_out, // Crank relay
    input wire stop_out, // Stop solenoid
    input wire [15:0] rpm_set, // Speed while running
    input wire sig_set, // Pickup present
    input wire [9:0] chg_set, // Charge level while running
    output wire [15:0] engine_speed, // Measured rpm
    output wire speed_signal_ok, // Pickup present
    output wire [9:0] charge_voltage, // Charge in 0.1 V
    output logic engine_running // Engine fired
);
    logic [3:0] crank_n;
    initial begin
        crank_n = 4'h0;
        engine_running = 1'b0;
    end
    // Fires only after several crank cycles so crank and choke are seen first
    always @(posedge hclk) begin
        crank_n <= crank_out ? crank_n + 4'h1 : 4'h0;
        if (!fuel_out || stop_out)
            engine_running <= 1'b0;
        else if (crank_n == 4'h8)
            engine_running <= 1'b1;
    end
    // A lost pickup reads as zero speed, as a real sensor would
    assign speed_signal_ok = sig_set;
    assign engine_speed = (engine_running && sig_set) ? rpm_set : 16'h0000;
    assign charge_voltage = engine_running ? chg_set : 10'h000;
endmodule // engine_model

// [engine_ctl_chk.sv]
// Checker for engine_ctl relay outputs and bus handshake.
// Assumes registered relay outputs sampled on hclk.
`timescale 1ns/10ps
module engine_ctl_chk (
    input wire hclk, // Bus clock
    input wire hresetn, // Reset, active low
    input wire hreadyout, // Slave ready
    input wire hresp, // Response
    input wire engine_running, // Engine fired
    input wire fuel_out, // Fuel solenoid
    input wire preheat_out, // Preheat relay
    input wire crank_out, // Crank relay
    input wire choke_out, // Choke relay
    input wire stop_out, // Stop solenoid
    input wire load_on_gen, // Load on genset
    input wire shutdown_out // Shutdown alarm
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_fire;
        $rose(engine_running) ##0 crank_out;
    endsequence
    sequence s_trip;
        $rose(shutdown_out);
    endsequence
    a_bus_ready: assert property (hreadyout && !hresp)
        else $error("bus not ready");
    a_choke_with_crank: assert property ($rose(crank_out) |-> choke_out)
        else $error("choke missing at crank");
    a_choke_on_fire: assert property (s_fire |-> ##[1:3] !choke_out)
        else $error("choke held after firing");
    a_crank_cut_fire: assert property (s_fire |-> ##[1:3] !crank_out)
        else $error("crank held after firing");
    a_preheat_fuel: assert property (preheat_out |-> fuel_out && !crank_out)
        else $error("preheat without fuel");
    a_load_after_heat: assert property (load_on_gen |-> !crank_out && !preheat_out)
        else $error("load while starting");
    a_trip_stops: assert property (s_trip |-> ##[0:3] (!fuel_out && !load_on_gen))
        else $error("shutdown did not stop");
    a_stop_no_fuel: assert property (stop_out |-> !fuel_out)
        else $error("stop with fuel on");
    a_reset_quiet: assert property ($rose(hresetn) |-> !fuel_out && !crank_out && !shutdown_out)
        else $error("outputs active after reset");
endmodule // engine_ctl_chk
bind engine_ctl engine_ctl_chk i_engine_ctl_chk (.*);

// [engine_ctl_tb.sv]
// Bench for engine_ctl: registers, start sequence and protections.
// Assumes the 1 s timebase, so timers under test are set to zero, or to 10 s where a fault must be held off.
`timescale 1ns/10ps
module engine_ctl_tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, mains_fail = 1'b0, sig_set = 1'b1;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0, freq_sel = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd;
    logic [15:0] rpm_set = 16'h05dc;
    logic [9:0] chg_set = 10'h078;
    wire [31:0] hrdata;
    wire [15:0] engine_speed;
    wire [9:0] charge_voltage;
    wire hreadyout, hresp, speed_signal_ok, engine_running, fuel_out, preheat_out, crank_out, choke_out;
    wire stop_out, load_on_gen, shutdown_out, loaddump_out, warning_out;
    int err_total = 0, checked = 0, cyc = 0;
    always #50 hclk = ~hclk;
    engine_ctl i_engine_ctl (.*, .hready(hreadyout), .coolant_temp(8'h19));
    engine_model i_engine_model (.*);
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            $display("[FAIL] run length expected finish seen hang");
            complete_run;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic poll(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        for (int n = 0; n < 300; n++) begin
            bus(a, 1'b0, 32'h0);
            if ((rd & m) === v)
                break;
        end
        chk(what, v, rd & m);
    endtask
    task automatic go_run;
        mains_fail <= 1'b1;
        poll("state run", 12'h024, 32'hff, 32'h40);
        chk("load on", 1'b1, load_on_gen);
    endtask
    task automatic go_idle;
        mains_fail <= 1'b0;
        rpm_set <= 16'h05dc;
        sig_set <= 1'b1;
        chg_set <= 10'h078;
        freq_sel <= 2'h0;
        poll("state idle", 12'h024, 32'hff, 32'h01);
        poll("alarms clear", 12'h028, 32'h7ff, 32'h0);
    endtask
    task automatic t_regs;
        logic [31:0] rv [12] = '{32'h05dc, 32'h0708, 32'h0708, 32'h0f0f0a0a, 32'h030a, 32'h0010a03c,
            32'h18530001, 32'h28780004, 32'h0, 32'h1, 32'h0, 32'h0};
        chk("outputs idle", 32'h0, {fuel_out, preheat_out, crank_out, choke_out, stop_out, load_on_gen});
        for (int i = 0; i < 12; i++) begin
            bus(12'(4 * i), 1'b0, 32'h0);
            chk($sformatf("reg %h", 4 * i), rv[i], rd);
        end
        bus(12'h000, 1'b1, 32'h0000ea60);
        bus(12'h000, 1'b0, 32'h0);
        chk("nominal clip", 32'h0000c350, rd);
        bus(12'h000, 1'b1, 32'h000005dc);
        bus(12'h024, 1'b1, 32'hffffffff);
        bus(12'h024, 1'b0, 32'h0);
        chk("status read only", 32'h1, rd);
    endtask
    task automatic t_start;
        int n;
        bus(12'h010, 1'b1, 32'h0000000a);
        bus(12'h014, 1'b1, 32'h0000a03c);
        bus(12'h018, 1'b1, 32'h08088000);
        bus(12'h01c, 1'b1, 32'h00000000);
        bus(12'h020, 1'b1, 32'h1);
        mains_fail <= 1'b1;
        for (n = 0; n < 2000 && crank_out !== 1'b1; n++)
            @(posedge hclk);
        chk("choke at crank", 1'b1, choke_out);
        chk("fuel at crank", 1'b1, fuel_out);
        chk("preheat off", 1'b0, preheat_out);
        go_run;
        chk("crank cut", 2'b00, {crank_out, choke_out});
        go_idle;
    endtask
    task automatic t_low_warn;
        go_run;
        rpm_set <= 16'h053c;
        poll("low warn", 12'h028, 32'h1, 32'h1);
        chk("low warn out", 4'h3, {shutdown_out, loaddump_out, warning_out, load_on_gen});
        go_idle;
    endtask
    task automatic t_freq;
        rpm_set <= 16'h0640;
        go_run;
        repeat (300) @(posedge hclk);
        bus(12'h028, 1'b0, 32'h0);
        chk("no warn primary", 32'h0, rd & 32'h3);
        freq_sel <= 2'h2;
        poll("low warn tertiary", 12'h028, 32'h1, 32'h1);
        go_idle;
    endtask
    task automatic t_high;
        go_run;
        rpm_set <= 16'h0690;
        poll("high warn", 12'h028, 32'h2, 32'h2);
        chk("high warn out", 2'b11, {warning_out, load_on_gen});
        go_idle;
    endtask
    task automatic t_low_shut;
        go_run;
        rpm_set <= 16'h04ec;
        poll("low shut", 12'h028, 32'h4, 32'h4);
        repeat (3) @(posedge hclk);
        chk("low shut stop", 3'b100, {shutdown_out, fuel_out, load_on_gen});
        go_idle;
    endtask
    task automatic t_over;
        bus(12'h010, 1'b1, 32'h00000a0a);
        go_run;
        rpm_set <= 16'h0708;
        repeat (1000) @(posedge hclk);
        bus(12'h028, 1'b0, 32'h0);
        chk("held by fail time", 32'h0, rd & 32'hf);
        rpm_set <= 16'h076c;
        poll("overshoot trip", 12'h028, 32'hf, 32'h8);
        go_idle;
    endtask
    task automatic t_sig;
        for (int act = 0; act < 4; act++) begin
            bus(12'h010, 1'b1, 32'h0a0a | (32'(act < 3) << 12) | (32'(act % 3) << 13));
            go_run;
            sig_set <= 1'b0;
            if (act < 3) begin
                poll("signal lost", 12'h028, 32'h70, 32'h10 << act);
                chk("lost action", 3'b100 >> act, {shutdown_out, loaddump_out, warning_out});
            end else begin
                repeat (1000) @(posedge hclk);
                bus(12'h028, 1'b0, 32'h0);
                chk("check off", 32'h0, rd & 32'h70);
            end
            go_idle;
        end
    endtask
    task automatic t_charge;
        go_run;
        chg_set <= 10'h037;
        poll("charge warn", 12'h028, 32'h180, 32'h080);
        chk("charge warn only", 1'b0, shutdown_out);
        chg_set <= 10'h023;
        poll("charge shut", 12'h028, 32'h100, 32'h100);
        repeat (3) @(posedge hclk);
        chk("charge stop", 3'b100, {shutdown_out, fuel_out, load_on_gen});
        go_idle;
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_start;
        t_low_warn;
        t_freq;
        t_high;
        t_low_shut;
        t_over;
        t_sig;
        t_charge;
        complete_run;
    end
endmodule // engine_ctl_tb
